// ---- hw/sga_pkg.sv ----
package sga_pkg;

  // ***********************************************************
  // Clock and timing
  // ***********************************************************
  localparam int SGA_CLK_HZ = 25_000_000;
  localparam int SGA_MIN_CMD_MS = 100;
  // Noise filter sits at half the shortest valid command
  localparam int SGA_FILTER_MS = 50;
  localparam int SGA_WAIT_S = 5;
  localparam int SGA_FILTER_CYC = SGA_CLK_HZ / 1000 * SGA_FILTER_MS;
  localparam int SGA_MIN_CMD_CYC = SGA_CLK_HZ / 1000 * SGA_MIN_CMD_MS;
  localparam int SGA_WAIT_CYC = SGA_CLK_HZ * SGA_WAIT_S;

  // ***********************************************************
  // Drive loop
  // ***********************************************************
  localparam int SGA_OPEN_COUNT = 400;
  localparam int SGA_TARGET_PERIOD = 2000;
  localparam logic [7:0] SGA_DUTY_START = 8'h40;
  localparam logic [7:0] SGA_DUTY_MAX = 8'hFF;
  localparam logic [7:0] SGA_DUTY_MIN = 8'h08;
  localparam logic [15:0] SGA_PERIOD_SAT = 16'hFFFF;

  // ***********************************************************
  // Register map
  // ***********************************************************
  localparam logic [3:0] SGA_REG_CTRL = 4'h0;
  localparam logic [3:0] SGA_REG_STATUS = 4'h4;
  localparam logic [3:0] SGA_REG_POS = 4'h8;
  localparam int SGA_CTRL_REMOTE_EN = 0;
  localparam int SGA_CTRL_ACS_EN = 1;
  localparam logic [1:0] SGA_CTRL_RESET = 2'h3;
  localparam int SGA_ST_STATE = 0;
  localparam int SGA_ST_MODE = 2;
  localparam int SGA_ST_DIR = 4;
  localparam int SGA_ST_REP_R = 5;
  localparam int SGA_ST_REP_L = 6;
  localparam int SGA_ST_PULSE = 7;
  localparam int SGA_ST_WAIT5 = 8;

  // ***********************************************************
  // Command channels in the filter array
  // ***********************************************************
  localparam int SGA_NCH = 9;
  localparam int SGA_CH_PANEL = 0;
  localparam int SGA_CH_REMOTE = 3;
  localparam int SGA_CH_ACS = 6;
  localparam int SGA_OFS_R = 0;
  localparam int SGA_OFS_L = 1;
  localparam int SGA_OFS_S = 2;

  typedef enum logic [1:0] {
    SGA_IDLE = 2'b00,
    SGA_OPENING = 2'b01,
    SGA_HOLD = 2'b11,
    SGA_CLOSING = 2'b10
  } sga_state_t;

  typedef enum logic [1:0] {
    SGA_LOCKED = 2'b00,
    SGA_SINGLE = 2'b01,
    SGA_FREE = 2'b10,
    SGA_HELD = 2'b11
  } sga_mode_t;

  typedef struct packed {
    logic stop_n;
    logic left_n;
    logic right_n;
  } sga_cmd_t;

  typedef struct packed {
    sga_state_t state;
    sga_mode_t mode;
    logic dir_right;
    logic [31:0] wait_cnt;
  } sga_ctl_t;

endpackage

// ---- hw/sga_gate.sv ----
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - Pulse style: low input requests its mode
// - Held style: mode lasts while input low
// - Held style: stop input ignored
// - Style jumper selects pulse or held
// - Wait jumper: 5 seconds or unlimited
// - Modes: locked, single passage, always free
// - Remote behaves like the desk panel
// - Drive panel, speed regulated by encoder
// - Reports open while gate at home
// - Only matching direction report closes
// - Report held closed while gate open
// - Mains loss makes its output non-conducting
// - Supply low makes its output non-conducting
// - Intruder relay bypasses gate logic
// - Red indicator while on backup supply
// - Right/left allow passage, stop locks
// - Unpowered or reset gate stays locked
module sga_gate
  import sga_pkg::*;
#(
  parameter int FILTER_CYC = SGA_FILTER_CYC,
  parameter int MIN_CMD_CYC = SGA_MIN_CMD_CYC,
  parameter int WAIT_CYC = SGA_WAIT_CYC,
  parameter int OPEN_COUNT = SGA_OPEN_COUNT,
  parameter int TARGET_PERIOD = SGA_TARGET_PERIOD
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire sga_cmd_t desk_operator_panel,
  input wire sga_cmd_t wireless_remote,
  input wire sga_cmd_t access_controller,
  input wire logic command_style_jumper,
  input wire logic wait_time_jumper,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic home_sensed,
  input wire logic passage_sensed,
  input wire logic mains_ok,
  input wire logic backup_supply_low,
  output logic motor_pwm,
  output logic motor_dir_right,
  output logic lock_release,
  output logic right_passage_report,
  output logic left_passage_report,
  output logic mains_loss_conducting,
  output logic supply_loss_conducting,
  output logic backup_supply_led
);

  localparam int CW = $clog2(FILTER_CYC + 1);

  // ***********************************************************
  // Parameter checks
  // ***********************************************************
  generate
    if (FILTER_CYC < 2 || FILTER_CYC >= MIN_CMD_CYC) begin : g_bad_filter
      $error("sga_gate: filter must be shorter than a valid command");
    end
    if (WAIT_CYC < 1 || OPEN_COUNT < 1 || OPEN_COUNT > 30000) begin : g_bad
      $error("sga_gate: wait or open count out of range");
    end
  endgenerate

  function automatic logic [7:0] sat_step(input logic [7:0] d,
                                          input logic up);
    logic [7:0] r;
    r = d;
    if (up && d < SGA_DUTY_MAX) begin
      r = d + 8'h01;
    end else if (!up && d > SGA_DUTY_MIN) begin
      r = d - 8'h01;
    end
    return r;
  endfunction

  // ***********************************************************
  // Jumper capture
  // ***********************************************************
  // Jumpers only move with power off, so one sample after reset is enough
  logic straps_taken, next_straps_taken;
  logic pulse_style, next_pulse_style;
  logic wait_limited, next_wait_limited;

  always_comb begin
    next_straps_taken = 1'b1;
    next_pulse_style = pulse_style;
    next_wait_limited = wait_limited;
    if (!straps_taken) begin
      next_pulse_style = command_style_jumper;
      next_wait_limited = wait_time_jumper;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      straps_taken <= 1'b0;
      pulse_style <= 1'b1;
      wait_limited <= 1'b1;
    end else begin
      straps_taken <= next_straps_taken;
      pulse_style <= next_pulse_style;
      wait_limited <= next_wait_limited;
    end
  end

  // ***********************************************************
  // Command filters
  // ***********************************************************
  logic [SGA_NCH-1:0] raw_low;
  logic [SGA_NCH-1:0] lvl;
  logic [SGA_NCH-1:0] ev;
  logic [CW-1:0] flt [SGA_NCH];
  logic [CW-1:0] next_flt [SGA_NCH];

  assign raw_low = ~{access_controller, wireless_remote, desk_operator_panel};

  always_comb begin
    for (int i = 0; i < SGA_NCH; i++) begin
      next_flt[i] = '0;
      lvl[i] = (flt[i] == CW'(FILTER_CYC));
      // Low must persist for the filter time before it counts
      ev[i] = raw_low[i] && (flt[i] == CW'(FILTER_CYC - 1));
      if (raw_low[i]) begin
        next_flt[i] = lvl[i] ? flt[i] : flt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < SGA_NCH; i++) begin
        flt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < SGA_NCH; i++) begin
        flt[i] <= next_flt[i];
      end
    end
  end

  // ***********************************************************
  // Software registers
  // ***********************************************************
  logic [1:0] ctrl, next_ctrl;
  logic [31:0] next_rdata;
  logic remote_en, acs_en;
  sga_ctl_t cur, nxt;
  logic signed [15:0] pos, next_pos;

  assign remote_en = ctrl[SGA_CTRL_REMOTE_EN];
  assign acs_en = ctrl[SGA_CTRL_ACS_EN];

  always_comb begin
    next_ctrl = ctrl;
    next_rdata = '0;
    if (reg_write && reg_addr == SGA_REG_CTRL) begin
      next_ctrl = reg_wdata[1:0];
    end
    if (reg_read) begin
      unique case (reg_addr)
        SGA_REG_CTRL: next_rdata = {30'h0, ctrl};
        SGA_REG_STATUS: begin
          next_rdata[SGA_ST_STATE +: 2] = cur.state;
          next_rdata[SGA_ST_MODE +: 2] = cur.mode;
          next_rdata[SGA_ST_DIR] = cur.dir_right;
          next_rdata[SGA_ST_REP_R] = right_passage_report;
          next_rdata[SGA_ST_REP_L] = left_passage_report;
          next_rdata[SGA_ST_PULSE] = pulse_style;
          next_rdata[SGA_ST_WAIT5] = wait_limited;
        end
        SGA_REG_POS: next_rdata = {{16{pos[15]}}, pos};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= SGA_CTRL_RESET;
      reg_rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      reg_rdata <= next_rdata;
    end
  end

  // ***********************************************************
  // Mode and sequence control
  // ***********************************************************
  logic req_right, req_left, req_stop, req_free;
  logic lvl_right, lvl_left, held_right, held_left, at_open, held_on;

  always_comb begin
    // Wireless commands merge as if pressed on the desk panel
    req_right = ev[SGA_CH_PANEL + SGA_OFS_R]
      | (remote_en & ev[SGA_CH_REMOTE + SGA_OFS_R])
      | (acs_en & pulse_style & ev[SGA_CH_ACS + SGA_OFS_R]);
    req_left = ev[SGA_CH_PANEL + SGA_OFS_L]
      | (remote_en & ev[SGA_CH_REMOTE + SGA_OFS_L])
      | (acs_en & pulse_style & ev[SGA_CH_ACS + SGA_OFS_L]);
    req_stop = ev[SGA_CH_PANEL + SGA_OFS_S]
      | (remote_en & ev[SGA_CH_REMOTE + SGA_OFS_S])
      | (acs_en & pulse_style & ev[SGA_CH_ACS + SGA_OFS_S]);
    lvl_right = lvl[SGA_CH_PANEL + SGA_OFS_R]
      | (remote_en & lvl[SGA_CH_REMOTE + SGA_OFS_R]);
    lvl_left = lvl[SGA_CH_PANEL + SGA_OFS_L]
      | (remote_en & lvl[SGA_CH_REMOTE + SGA_OFS_L]);
    // A direction button pressed while the other is already held selects always free
    req_free = (req_right & lvl_left) | (req_left & lvl_right);
    held_right = acs_en & ~pulse_style & lvl[SGA_CH_ACS + SGA_OFS_R];
    held_left = acs_en & ~pulse_style & lvl[SGA_CH_ACS + SGA_OFS_L];
    held_on = cur.dir_right ? held_right : held_left;
    at_open = cur.dir_right ? (pos >= $signed(16'(OPEN_COUNT)))
                            : (pos <= -$signed(16'(OPEN_COUNT)));

    nxt = cur;
    if (req_stop) begin
      nxt.mode = SGA_LOCKED;
    end else if (req_free) begin
      nxt.mode = SGA_FREE;
    end else if (req_right || req_left) begin
      nxt.mode = SGA_SINGLE;
      nxt.wait_cnt = '0;
      if (cur.state == SGA_IDLE) begin
        nxt.dir_right = req_right;
      end
    end else if (cur.mode == SGA_HELD && !held_on) begin
      nxt.mode = SGA_LOCKED;
    end else if (cur.mode == SGA_LOCKED && cur.state == SGA_IDLE
                 && (held_right || held_left)) begin
      nxt.mode = SGA_HELD;
      nxt.dir_right = held_right;
    end

    unique case (cur.state)
      SGA_IDLE: begin
        if (cur.mode != SGA_LOCKED) begin
          nxt.state = SGA_OPENING;
        end
      end
      SGA_OPENING: begin
        if (nxt.mode == SGA_LOCKED) begin
          nxt.state = SGA_CLOSING;
        end else if (at_open) begin
          nxt.state = SGA_HOLD;
          nxt.wait_cnt = '0;
        end
      end
      SGA_HOLD: begin
        if (nxt.mode == SGA_LOCKED) begin
          nxt.state = SGA_CLOSING;
        end else if (cur.mode == SGA_SINGLE && nxt.mode == SGA_SINGLE) begin
          if (passage_sensed || (wait_limited
              && cur.wait_cnt >= 32'(WAIT_CYC - 1))) begin
            nxt.state = SGA_CLOSING;
            nxt.mode = SGA_LOCKED;
          end else if (wait_limited) begin
            nxt.wait_cnt = cur.wait_cnt + 32'h0000_0001;
          end
        end
      end
      SGA_CLOSING: begin
        if (home_sensed) begin
          nxt.state = SGA_IDLE;
        end else if (nxt.mode != SGA_LOCKED) begin
          nxt.state = SGA_OPENING;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{state: SGA_IDLE, mode: SGA_LOCKED, dir_right: 1'b1,
               wait_cnt: 32'h0};
    end else begin
      cur <= nxt;
    end
  end

  // ***********************************************************
  // Encoder position and speed loop
  // ***********************************************************
  // Speed is held by nudging duty one step per encoder edge; slow but
  // free of overshoot on a heavy panel
  logic a_q, b_q, next_a_q, next_b_q;
  logic [15:0] period, next_period;
  logic [7:0] duty, next_duty, pwm_cnt, next_pwm_cnt;
  logic moving, step, up;

  always_comb begin
    moving = (cur.state == SGA_OPENING) || (cur.state == SGA_CLOSING);
    step = (enc_a ^ a_q) | (enc_b ^ b_q);
    up = a_q ^ enc_b;
    next_a_q = enc_a;
    next_b_q = enc_b;
    next_pos = pos;
    next_pwm_cnt = pwm_cnt + 8'h01;
    next_period = (period == SGA_PERIOD_SAT) ? period : period + 16'h0001;
    next_duty = duty;
    if (home_sensed) begin
      next_pos = '0;
    end else if (step) begin
      next_pos = up ? pos + 16'sd1 : pos - 16'sd1;
    end
    if (!moving) begin
      next_duty = SGA_DUTY_START;
      next_period = '0;
    end else if (step) begin
      next_duty = sat_step(duty, period > 16'(TARGET_PERIOD));
      next_period = '0;
    end else if (period == SGA_PERIOD_SAT) begin
      next_duty = sat_step(duty, 1'b1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      pos <= '0;
      period <= '0;
      duty <= SGA_DUTY_START;
      pwm_cnt <= '0;
    end else begin
      a_q <= next_a_q;
      b_q <= next_b_q;
      pos <= next_pos;
      period <= next_period;
      duty <= next_duty;
      pwm_cnt <= next_pwm_cnt;
    end
  end

  // ***********************************************************
  // Output stages
  // ***********************************************************
  // The intruder relay is wired detector to connector and has no port
  // here
  logic gate_out;
  assign gate_out = nxt.state != SGA_IDLE;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      motor_pwm <= 1'b0;
      motor_dir_right <= 1'b0;
      lock_release <= 1'b0;
      right_passage_report <= 1'b0;
      left_passage_report <= 1'b0;
      mains_loss_conducting <= 1'b0;
      supply_loss_conducting <= 1'b0;
      backup_supply_led <= 1'b0;
    end else begin
      motor_pwm <= moving && (pwm_cnt < duty);
      motor_dir_right <= (cur.state == SGA_OPENING) ? cur.dir_right
                                                    : ~cur.dir_right;
      lock_release <= gate_out;
      right_passage_report <= gate_out & nxt.dir_right;
      left_passage_report <= gate_out & ~nxt.dir_right;
      mains_loss_conducting <= mains_ok;
      supply_loss_conducting <= ~backup_supply_low;
      backup_supply_led <= ~mains_ok;
    end
  end

endmodule

// ---- testbench/sga_gate_chk_sva.sv ----
`timescale 1ns/1ns
// ***********************************************************
// Port checker
// ***********************************************************
module sga_gate_chk
  import sga_pkg::*;
#(
  parameter int FILTER_CYC = SGA_FILTER_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire sga_cmd_t desk_operator_panel,
  input wire sga_cmd_t wireless_remote,
  input wire sga_cmd_t access_controller,
  input wire logic home_sensed,
  input wire logic mains_ok,
  input wire logic backup_supply_low,
  input wire logic motor_pwm,
  input wire logic lock_release,
  input wire logic right_passage_report,
  input wire logic left_passage_report,
  input wire logic mains_loss_conducting,
  input wire logic supply_loss_conducting,
  input wire logic backup_supply_led
);
  logic any_low;
  logic [31:0] low_run;
  logic [31:0] next_low_run;
  logic armed;
  logic next_armed;
  assign any_low = ~&{desk_operator_panel, wireless_remote,
                      access_controller};
  // Armed only once some input stayed low the whole filter span
  always_comb begin
    next_low_run = any_low ? low_run + 32'h1 : 32'h0;
    next_armed = lock_release ? 1'b0 : armed;
    if (low_run >= FILTER_CYC - 1) begin
      next_armed = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_run <= 32'h0;
      armed <= 1'b0;
    end else begin
      low_run <= next_low_run;
      armed <= next_armed;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_reports_exclusive: assert property (
    !(right_passage_report && left_passage_report))
    else $error("both passage reports closed");
  a_report_needs_lock: assert property (
    (right_passage_report || left_passage_report) |-> lock_release)
    else $error("report closed while locked");
  a_home_reports_open: assert property (
    (home_sensed && !lock_release) |->
      !right_passage_report && !left_passage_report)
    else $error("report closed at home");
  a_report_holds: assert property (
    (right_passage_report && !home_sensed) |=> right_passage_report)
    else $error("report dropped while gate open");
  a_mains_loss: assert property (
    $fell(mains_ok) |=> !mains_loss_conducting && backup_supply_led)
    else $error("mains loss not signalled");
  a_supply_loss: assert property (
    $rose(backup_supply_low) |-> ##1 !supply_loss_conducting)
    else $error("supply loss not signalled");
  a_filter_first: assert property (
    $rose(lock_release) |-> armed)
    else $error("gate released on a short command");
  a_motor_still: assert property (
    (!lock_release && $past(!lock_release)) |-> !motor_pwm)
    else $error("motor driven while locked");
  a_rdata_quiet: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind sga_gate sga_gate_chk #(.FILTER_CYC(FILTER_CYC)) i_sga_gate_chk (
  .clock, .arst_n, .reg_read, .reg_rdata, .desk_operator_panel,
  .wireless_remote, .access_controller, .home_sensed, .mains_ok,
  .backup_supply_low, .motor_pwm, .lock_release, .right_passage_report,
  .left_passage_report, .mains_loss_conducting, .supply_loss_conducting,
  .backup_supply_led
);

// ---- testbench/sga_acs_model.sv ----
`timescale 1ns/1ns
// ***********************************************************
// External access controller
// ***********************************************************
module sga_acs_model
  import sga_pkg::*;
#(
  parameter int MIN_CMD_CYC = SGA_MIN_CMD_CYC
) (
  input wire logic clock,
  output sga_cmd_t access_controller
);
  // Released open-collector lines sit at the pull-up level
  initial access_controller = 3'b111;
  // Short requests are stretched, the controller never sends less
  task automatic press(input sga_cmd_t v, input int n);
    @(posedge clock);
    access_controller <= v;
    repeat ((n < MIN_CMD_CYC) ? MIN_CMD_CYC : n) @(posedge clock);
    access_controller <= 3'b111;
  endtask
  task automatic level(input sga_cmd_t v);
    @(posedge clock);
    access_controller <= v;
  endtask
endmodule

// ---- testbench/tb_sga_gate.sv ----
`timescale 1ns/1ns
module tb_sga_gate
  import sga_pkg::*;
;
  typedef struct packed {
    logic [1:0] src;
    sga_cmd_t cmd;
    logic [1:0] rep;
  } sga_row_t;
  localparam sga_row_t ROWS [6] = '{
    '{2'd0, 3'b110, 2'b10}, '{2'd0, 3'b101, 2'b01},
    '{2'd1, 3'b110, 2'b10}, '{2'd1, 3'b101, 2'b01},
    '{2'd2, 3'b110, 2'b10}, '{2'd2, 3'b101, 2'b01}};
  logic clock, arst_n, reg_write, reg_read, style_j, wait_j;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  sga_cmd_t panel, remote, acs;
  logic enc_a, enc_b, home_sensed, mains_ok, supply_low;
  logic motor_pwm, motor_dir, lock, rep_r, rep_l, ml_c, sl_c, led;
  logic [1:0] q;
  logic pwm_d, passage;
  int pos, mismatches, checks;
  sga_gate #(.FILTER_CYC(8), .MIN_CMD_CYC(16), .WAIT_CYC(50),
    .OPEN_COUNT(4), .TARGET_PERIOD(10)) i_sga_gate (
    .clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .desk_operator_panel(panel), .wireless_remote(remote),
    .access_controller(acs), .command_style_jumper(style_j),
    .wait_time_jumper(wait_j), .enc_a, .enc_b, .home_sensed,
    .passage_sensed(passage), .mains_ok, .backup_supply_low(supply_low),
    .motor_pwm, .motor_dir_right(motor_dir), .lock_release(lock),
    .right_passage_report(rep_r), .left_passage_report(rep_l),
    .mains_loss_conducting(ml_c), .supply_loss_conducting(sl_c),
    .backup_supply_led(led));
  sga_acs_model #(.MIN_CMD_CYC(16)) i_sga_acs_model (
    .clock, .access_controller(acs));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ***********************************************************
  // Panel mechanics: one encoder step per drive pulse
  // ***********************************************************
  assign enc_a = q[1];
  assign enc_b = q[1] ^ q[0];
  assign home_sensed = (pos == 0);
  initial {q, pwm_d, pos} = '0;
  always @(posedge clock) begin
    pwm_d <= motor_pwm;
    if (motor_pwm && !pwm_d) begin
      q <= motor_dir ? q + 2'd1 : q - 2'd1;
      pos <= motor_dir ? pos + 1 : pos - 1;
    end
  end
  // ***********************************************************
  // Tasks
  // ***********************************************************
  task automatic final_report();
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // w selects lock (0) or any report (1); bounded wait
  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    // Look only where registered outputs have settled
    @(negedge clock);
    while (((w == 0) ? lock : (rep_r | rep_l)) !== v) begin
      @(negedge clock);
      n++;
      if (n > 8000) begin
        mismatches++;
        $display("ERROR wait %0d expected %b seen timeout", w, v);
        final_report();
      end
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  task automatic send(input logic [1:0] s, input sga_cmd_t v, input int n);
    if (s == 2'd2) begin
      i_sga_acs_model.press(v, n);
    end else begin
      @(posedge clock);
      if (s == 2'd0) panel <= v;
      else remote <= v;
      repeat (n) @(posedge clock);
      panel <= 3'b111;
      remote <= 3'b111;
    end
  endtask
  // ***********************************************************
  // Sequence
  // ***********************************************************
  initial begin
    {arst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {panel, remote, style_j, wait_j, mains_ok} = '1;
    {supply_low, passage} = '0;
    {mismatches, checks} = '0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk("lock", 32'h0, 32'(lock));
    chk("reports", 32'h0, 32'({rep_r, rep_l}));
    rd(SGA_REG_CTRL, d);
    chk("ctrl", 32'h3, d);
    rd(4'hC, d);
    chk("unmapped", 32'h0, d);
    rd(SGA_REG_STATUS, d);
    chk("pulse style", 32'h1, 32'(d[SGA_ST_PULSE]));
    foreach (ROWS[i]) begin
      send(ROWS[i].src, ROWS[i].cmd, 16);
      wait_for(1, 1'b1);
      chk("reports", 32'(ROWS[i].rep), 32'({rep_r, rep_l}));
      chk("direction", 32'(ROWS[i].rep[1]), 32'(motor_dir));
      wait_for(0, 1'b0);
      chk("reports idle", 32'h0, 32'({rep_r, rep_l}));
      rd(SGA_REG_STATUS, d);
      chk("mode", 32'(SGA_LOCKED), 32'(d[3:2]));
    end
    // Left held first, right joins later: both together mean always free
    @(posedge clock);
    panel <= 3'b101;
    repeat (4) @(posedge clock);
    panel <= 3'b100;
    repeat (16) @(posedge clock);
    panel <= 3'b111;
    repeat (2000) @(negedge clock);
    rd(SGA_REG_STATUS, d);
    chk("free mode", 32'(SGA_FREE), 32'(d[3:2]));
    chk("free lock", 32'h1, 32'(lock));
    send(2'd0, 3'b011, 16);
    wait_for(0, 1'b0);
    rd(SGA_REG_STATUS, d);
    chk("stop mode", 32'(SGA_LOCKED), 32'(d[3:2]));
    send(2'd0, 3'b110, 5);
    repeat (40) @(negedge clock);
    chk("short press", 32'h0, 32'(lock));
    wr(SGA_REG_CTRL, 32'h2);
    send(2'd1, 3'b110, 16);
    repeat (40) @(negedge clock);
    chk("remote off", 32'h0, 32'(lock));
    wr(SGA_REG_CTRL, 32'h3);
    @(posedge clock);
    mains_ok <= 1'b0;
    supply_low <= 1'b1;
    repeat (2) @(negedge clock);
    chk("mains loss", 32'h0, 32'(ml_c));
    chk("supply loss", 32'h0, 32'(sl_c));
    chk("red led", 32'h1, 32'(led));
    @(posedge clock);
    mains_ok <= 1'b1;
    supply_low <= 1'b0;
    arst_n <= 1'b0;
    style_j <= 1'b0;
    wait_j <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    i_sga_acs_model.level(3'b110);
    wait_for(1, 1'b1);
    chk("held report", 32'h1, 32'(rep_r));
    i_sga_acs_model.level(3'b010);
    repeat (20) @(negedge clock);
    chk("held stop", 32'h1, 32'(lock));
    rd(SGA_REG_STATUS, d);
    chk("held mode", 32'(SGA_HELD), 32'(d[3:2]));
    i_sga_acs_model.level(3'b111);
    wait_for(0, 1'b0);
    rd(SGA_REG_STATUS, d);
    chk("held style", 32'h0, 32'(d[SGA_ST_PULSE]));
    chk("wait jumper", 32'h0, 32'(d[SGA_ST_WAIT5]));
    // Unlimited wait: the gate stays open until someone walks through
    send(2'd0, 3'b110, 16);
    repeat (2000) @(negedge clock);
    rd(SGA_REG_STATUS, d);
    chk("no time limit", 32'(SGA_HOLD), 32'(d[1:0]));
    @(posedge clock);
    passage <= 1'b1;
    @(posedge clock);
    passage <= 1'b0;
    wait_for(0, 1'b0);
    rd(SGA_REG_STATUS, d);
    chk("after passage", 32'(SGA_LOCKED), 32'(d[3:2]));
    final_report();
  end
endmodule
